// >>> shared/rir_cfg.svh
`ifndef RIR_CFG_SVH
`define RIR_CFG_SVH

// Register byte addresses on the internal register port.
`define RIR_CONF_BASE 8'h02
`define RIR_MASK_BASE 8'h90
`define RIR_STAT_BASE 8'hFA

// Pin configuration byte fields.
`define RIR_SEL_MSB 7
`define RIR_SEL_LSB 3
`define RIR_MODE_MSB 1
`define RIR_MODE_LSB 0

// Reset values.
`define RIR_CONF_RST 8'hA2
`define RIR_MASK_RST 32'h0000_0000
`define RIR_FLAG_RST 32'h0000_0000

// Pin mode codes.
`define RIR_MODE_IN 2'h1
`define RIR_MODE_OUT_LP 2'h2
`define RIR_MODE_OUT_HP 2'h3

// Output selection code carrying the request.
`define RIR_OSEL_IRQ 5'h00

// Input selection codes.
`define RIR_ISEL_TX_CMD 5'h00
`define RIR_ISEL_RX_CMD 5'h01
`define RIR_ISEL_TX_DATA 5'h02
`define RIR_ISEL_WAKEUP 5'h03
`define RIR_ISEL_LF_CLK 5'h04

// Event flag positions and implemented flag set.
`define RIR_BIT_WAKEUP 15
`define RIR_BIT_READY 16
`define RIR_FLAG_IMPL 32'h603F_FFFF

`endif

// >>> shared/rir_pkg.sv
package rir_pkg;

  // Sources for output selection codes 31 down to 1; code 0 is the request.
  typedef struct packed {
    logic wait_rc_cal;
    logic synthesizer_enable;
    logic wait_vco_cal;
    logic wait_pm_settle;
    logic wait_osc_settled;
    logic wait_lock_timer;
    logic wait_lock_det;
    logic lock_state;
    logic not_sleep_stby;
    logic sleep_stby;
    logic smps_enable;
    logic const_low;
    logic const_high;
    logic tx_or_rx;
    logic mcu_clk;
    logic carrier_sense;
    logic sync_flag;
    logic preamble_flag;
    logic ant_switch;
    logic rx_fifo_aempty;
    logic rx_fifo_afull;
    logic rx_state;
    logic rx_clk;
    logic rx_data;
    logic tx_fifo_afull;
    logic tx_fifo_aempty;
    logic tx_state;
    logic tx_data_clk;
    logic low_battery;
    logic wakeup_timer_expired;
    logic por_n;
  } rir_out_src_t;

  // Functions taken from pins in input mode.
  typedef struct packed {
    logic tx_cmd;
    logic rx_cmd;
    logic tx_data;
    logic ext_wakeup;
    logic ext_lf_clk;
  } rir_pin_in_t;

endpackage

// >>> logic/rir_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the level follows once stages two and three agree.
module rir_pin_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Pin
  input wire logic pin_i,
  output logic level_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  wire agree = (s2_ff == s3_ff);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= 1'h0;
      s2_ff <= 1'h0;
      s3_ff <= 1'h0;
      level_ff <= 1'h0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_o = level_ff;

endmodule

// >>> logic/rir_irq_pin_route.sv
`timescale 1ns/1ps
`include "rir_cfg.svh"
// Operation
// - Code 0 drives active-low request on pin
// - Packet events use flag bits 0 to 11
// - Signal quality events use bits 12 to 14
// - Device status events use bits 15 to 21
// - RX timeout bit 29, AES done bit 30
// - Flag bits read high after event, four bytes
// - Reading status clears the flags read
// - Mask bit zero blocks that event's request
// - Wake flag set only while crystal runs
// - Ready flag set on settled ready entry
// - Four pins, each separately configured
// - Codes 1-3: reset_n, wake expired, low battery
// - Codes 4-8: TX clock, state, FIFO, RX data
// - Further status and constant outputs selectable
// - Internal sequencing states selectable on pins
// - Input codes 0,1 trigger TX, RX commands
// - Input codes 2,3: TX data, external wake
// - Input code 4 low-rate clock; 5-31 unused
// - Mode 01 input, 10 low, 11 high power
// - Host reaches registers through the serial link
module rir_irq_pin_route
  import rir_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port from the serial link engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Events and state
  input wire logic [31:0] evt_i,
  input wire logic xo_running_i,
  input wire logic ready_state_i,
  input wire logic osc_settled_i,
  input wire rir_out_src_t dev_sig_i,
  // Pins
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_n_o,
  output logic [3:0] pin_hp_o,
  // Pin input functions and request
  output rir_pin_in_t pin_in_o,
  output logic irq_request_n_o
);

  logic [31:0] flags_ff;
  logic [31:0] mask_ff;
  logic [7:0] conf_ff [4];
  logic [7:0] rdata_ff;
  logic irq_n_ff;
  logic wut_prev_ff;
  logic wut_pend_ff;
  logic rdy_prev_ff;
  logic [3:0] lvl_prev_ff;
  logic [3:0] pin_o_ff;
  logic [3:0] oe_n_ff;
  logic [3:0] hp_ff;
  rir_pin_in_t pin_in_ff;

  logic [3:0] lvl;
  logic [3:0] conf_hit;
  logic [3:0] mask_hit;
  logic [3:0] stat_hit;
  logic [7:0] conf_term [4];
  logic [7:0] mask_term [4];
  logic [7:0] stat_term [4];
  logic [31:0] rd_clr;
  logic [3:0] drive;
  logic [3:0] in_mode;
  logic [3:0] nxt_pin_o;
  logic [3:0] is_tx_cmd;
  logic [3:0] is_rx_cmd;
  logic [3:0] is_tx_data;
  logic [3:0] is_wakeup;
  logic [3:0] is_lf_clk;

  // The request itself is code 0; the remaining codes follow the source struct.
  wire [31:0] out_src = {dev_sig_i, irq_n_ff};

  // Wake flag waits until the crystal clock is available to the state machine.
  wire wut_rise = dev_sig_i.wakeup_timer_expired & ~wut_prev_ff;
  wire wut_set = (wut_pend_ff | wut_rise) & xo_running_i;
  wire nxt_wut_pend = (wut_pend_ff | wut_rise) & ~xo_running_i;
  wire rdy_cond = ready_state_i & osc_settled_i;
  wire rdy_set = rdy_cond & ~rdy_prev_ff;

  wire [31:0] set_vec = {evt_i[31:17], rdy_set, wut_set, evt_i[14:0]} & `RIR_FLAG_IMPL;
  // A new event wins over the read clear in the same cycle.
  wire [31:0] nxt_flags = (flags_ff & ~rd_clr) | set_vec;
  wire nxt_irq_n = ~|(flags_ff & mask_ff);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_byte
      assign conf_hit[g] = (reg_addr_i == `RIR_CONF_BASE + 8'(3 - g));
      assign mask_hit[g] = (reg_addr_i == `RIR_MASK_BASE + 8'(3 - g));
      assign stat_hit[g] = (reg_addr_i == `RIR_STAT_BASE + 8'(3 - g));
      assign conf_term[g] = conf_hit[g] ? conf_ff[g] : 8'h00;
      assign mask_term[g] = mask_hit[g] ? mask_ff[g*8 +: 8] : 8'h00;
      assign stat_term[g] = stat_hit[g] ? flags_ff[g*8 +: 8] : 8'h00;
      assign rd_clr[g*8 +: 8] = {8{reg_rd_i & stat_hit[g]}};

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mask_ff[g*8 +: 8] <= 8'(`RIR_MASK_RST >> (8 * g));
        end else if (reg_wr_i && mask_hit[g]) begin
          mask_ff[g*8 +: 8] <= reg_wdata_i;
        end
      end
    end

    for (g = 0; g < 4; g = g + 1) begin : g_pin
      wire [4:0] sel = conf_ff[g][`RIR_SEL_MSB:`RIR_SEL_LSB];
      wire [1:0] mode = conf_ff[g][`RIR_MODE_MSB:`RIR_MODE_LSB];

      rir_pin_sync u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .pin_i(pin_i[g]),
        .level_o(lvl[g])
      );

      assign in_mode[g] = (mode == `RIR_MODE_IN);
      assign drive[g] = (mode == `RIR_MODE_OUT_LP) | (mode == `RIR_MODE_OUT_HP);
      assign nxt_pin_o[g] = drive[g] & out_src[sel];
      assign is_tx_cmd[g] = in_mode[g] & (sel == `RIR_ISEL_TX_CMD) & lvl[g] & ~lvl_prev_ff[g];
      assign is_rx_cmd[g] = in_mode[g] & (sel == `RIR_ISEL_RX_CMD) & lvl[g] & ~lvl_prev_ff[g];
      assign is_tx_data[g] = in_mode[g] & (sel == `RIR_ISEL_TX_DATA) & lvl[g];
      assign is_wakeup[g] = in_mode[g] & (sel == `RIR_ISEL_WAKEUP) & lvl[g];
      assign is_lf_clk[g] = in_mode[g] & (sel == `RIR_ISEL_LF_CLK) & lvl[g];

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          conf_ff[g] <= `RIR_CONF_RST;
          lvl_prev_ff[g] <= 1'h0;
          pin_o_ff[g] <= 1'h0;
          oe_n_ff[g] <= 1'h1;
          hp_ff[g] <= 1'h0;
        end else begin
          if (reg_wr_i && conf_hit[g]) begin
            conf_ff[g] <= reg_wdata_i;
          end
          lvl_prev_ff[g] <= lvl[g];
          pin_o_ff[g] <= nxt_pin_o[g];
          oe_n_ff[g] <= ~drive[g];
          hp_ff[g] <= (mode == `RIR_MODE_OUT_HP);
        end
      end
    end
  endgenerate

  wire [7:0] rd_mux = conf_term[0] | conf_term[1] | conf_term[2] | conf_term[3] |
                      mask_term[0] | mask_term[1] | mask_term[2] | mask_term[3] |
                      stat_term[0] | stat_term[1] | stat_term[2] | stat_term[3];

  wire rir_pin_in_t nxt_pin_in = '{tx_cmd: |is_tx_cmd, rx_cmd: |is_rx_cmd, tx_data: |is_tx_data,
                                   ext_wakeup: |is_wakeup, ext_lf_clk: |is_lf_clk};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= `RIR_FLAG_RST;
      irq_n_ff <= 1'h1;
      wut_prev_ff <= 1'h0;
      wut_pend_ff <= 1'h0;
      rdy_prev_ff <= 1'h0;
    end else begin
      flags_ff <= nxt_flags;
      irq_n_ff <= nxt_irq_n;
      wut_prev_ff <= dev_sig_i.wakeup_timer_expired;
      wut_pend_ff <= nxt_wut_pend;
      rdy_prev_ff <= rdy_cond;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
      pin_in_ff <= '0;
    end else begin
      if (reg_rd_i) begin
        rdata_ff <= rd_mux;
      end
      pin_in_ff <= nxt_pin_in;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign irq_request_n_o = irq_n_ff;
  assign pin_o = pin_o_ff;
  assign pin_oe_n_o = oe_n_ff;
  assign pin_hp_o = hp_ff;
  assign pin_in_o = pin_in_ff;

  // Checks on the request, flag and pin paths.
  irq_assert_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (|(flags_ff & mask_ff)) |=> !irq_request_n_o)
    else $error("Request not asserted for unmasked flag.");

  mask_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mask_ff == 32'h0000_0000) |=> irq_request_n_o)
    else $error("Request asserted with every event masked.");

  read_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (reg_rd_i && stat_hit[0] && set_vec[7:0] == 8'h00) |=> (flags_ff[7:0] == 8'h00) && (reg_rdata_o == $past(flags_ff[7:0])))
    else $error("Status byte not returned and cleared on read.");

  packet_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    evt_i[0] |=> flags_ff[0] ##1 (flags_ff[0] || $past(reg_rd_i && stat_hit[0])))
    else $error("Packet event flag lost.");

  quality_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    evt_i[13] |=> flags_ff[13])
    else $error("Quality event flag not set.");

  aes_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (evt_i[30] && evt_i[29]) |=> (flags_ff[30] && flags_ff[29]))
    else $error("Timeout or AES flag not set.");

  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (flags_ff[28:22] == 7'h00) && !flags_ff[31])
    else $error("Unused flag bit became set.");

  wake_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(flags_ff[`RIR_BIT_WAKEUP]) |-> $past(xo_running_i))
    else $error("Wake flag set without crystal clock.");

  ready_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rdy_cond && !rdy_prev_ff) |=> flags_ff[`RIR_BIT_READY])
    else $error("Ready flag not set on settled ready entry.");

  irq_route_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (drive[0] && conf_ff[0][`RIR_SEL_MSB:`RIR_SEL_LSB] == `RIR_OSEL_IRQ) |=>
      (pin_o[0] == $past(irq_request_n_o)) && !pin_oe_n_o[0])
    else $error("Pin does not carry the request.");

  input_float_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_mode[1] |=> pin_oe_n_o[1] && !pin_hp_o[1])
    else $error("Input pin is being driven.");

  tx_cmd_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    is_tx_cmd[2] |=> pin_in_o.tx_cmd ##1 !pin_in_o.tx_cmd)
    else $error("TX command not a single pulse.");

  irq_seen_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $fell(irq_request_n_o));
  read_clr_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) reg_rd_i && |stat_term[1]);
  wake_pend_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) wut_pend_ff ##1 wut_set);
  rx_cmd_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) pin_in_o.rx_cmd);

endmodule

// >>> tb/rir_host_pins.sv
`timescale 1ns/1ps
// Host side of the four pads: drives the pads it owns, otherwise sees the device or a moving pattern.
module rir_host_pins (
  // Clock
  input wire logic mclk_i,
  // Device pad side
  input wire logic [3:0] pin_o_i,
  input wire logic [3:0] pin_oe_n_i,
  // Host drive control
  input wire logic [3:0] drv_en_i,
  input wire logic [3:0] drv_val_i,
  // Resolved pads
  output logic [3:0] pad_o
);
  logic [3:0] idle_ff = 4'h5;
  always_ff @(posedge mclk_i) begin
    idle_ff <= ~idle_ff;
  end
  // Undriven pads toggle so that a stale level never passes for a real one.
  assign pad_o = (~pin_oe_n_i & pin_o_i) | (pin_oe_n_i & drv_en_i & drv_val_i) |
                 (pin_oe_n_i & ~drv_en_i & idle_ff);
endmodule

// >>> tb/radio_irq_and_pin_routing_tb.sv
`timescale 1ns/1ps
`include "rir_cfg.svh"
module radio_irq_and_pin_routing_tb import rir_pkg::*; ;
  logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic xo_running_i = 0, ready_state_i = 0, osc_settled_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [31:0] evt_i = 32'h0, exp;
  rir_out_src_t dev_sig_i = '0;
  logic [3:0] pin_i, pin_o, pin_oe_n_o, pin_hp_o, drv_en = 4'h0, drv_val = 4'h0;
  rir_pin_in_t pin_in_o;
  logic irq_request_n_o;
  logic [4:0] acc;
  int fails = 0, checks_done = 0, cnt;

  rir_irq_pin_route dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .evt_i(evt_i),
    .xo_running_i(xo_running_i), .ready_state_i(ready_state_i), .osc_settled_i(osc_settled_i),
    .dev_sig_i(dev_sig_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pin_hp_o(pin_hp_o),
    .pin_in_o(pin_in_o), .irq_request_n_o(irq_request_n_o));
  rir_host_pins host (.mclk_i(mclk_i), .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n_o), .drv_en_i(drv_en),
    .drv_val_i(drv_val), .pad_o(pin_i));

  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 check_eq(reg_rdata_o, want);
  endtask
  task automatic pulse(input logic [31:0] e);
    @(posedge mclk_i);
    evt_i <= e;
    @(posedge mclk_i);
    evt_i <= 32'h0;
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 8 && irq_request_n_o !== lvl; i++) @(posedge mclk_i);
    #1 check_eq(irq_request_n_o, lvl);
  endtask

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    #3000000;
    fails++;
    finish_test();
  end
  initial begin
    cycles(12);
    rst_n_i <= 1'b1;
    cycles(3);
    check_eq(irq_request_n_o, 1'b1);
    check_eq({pin_oe_n_o, pin_o}, 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(`RIR_CONF_BASE + i, `RIR_CONF_RST);
    for (int i = 0; i < 4; i++) rd_chk(`RIR_STAT_BASE + i, 8'h00);
    rd_chk(8'h40, 8'h00);
    // Every event at once; only the documented positions may latch.
    pulse(32'hFFFF_FFFF);
    exp = `RIR_FLAG_IMPL & ~32'h0001_8000;
    for (int i = 0; i < 4; i++) rd_chk(`RIR_STAT_BASE + i, exp[31-8*i -: 8]);
    for (int i = 0; i < 4; i++) rd_chk(`RIR_STAT_BASE + i, 8'h00);
    reg_wr(`RIR_STAT_BASE + 3, 8'hFF);
    rd_chk(`RIR_STAT_BASE + 3, 8'h00);
    for (int i = 0; i < 4; i++) reg_wr(`RIR_MASK_BASE + i, 8'h5A + i);
    for (int i = 0; i < 4; i++) rd_chk(`RIR_MASK_BASE + i, 8'h5A + i);
    for (int i = 0; i < 3; i++) reg_wr(`RIR_MASK_BASE + i, 8'h00);
    reg_wr(`RIR_MASK_BASE + 3, 8'h01);
    // Request on pin 0, masked and unmasked events.
    reg_wr(`RIR_CONF_BASE + 3, 8'h02);
    pulse(32'h2);
    cycles(4);
    check_eq({irq_request_n_o, pin_o[0]}, 2'b11);
    pulse(32'h1);
    wait_irq(1'b0);
    cycles(2);
    check_eq(pin_o[0], 1'b0);
    rd_chk(`RIR_STAT_BASE + 3, 8'h03);
    wait_irq(1'b1);
    // Wake flag waits for the crystal; the raw signal reaches the pin at once.
    reg_wr(`RIR_CONF_BASE + 2, 8'h13);
    dev_sig_i.wakeup_timer_expired <= 1'b1;
    cycles(3);
    check_eq({pin_oe_n_o[1], pin_hp_o[1], pin_o[1]}, 3'b011);
    rd_chk(`RIR_STAT_BASE + 2, 8'h00);
    xo_running_i <= 1'b1;
    cycles(3);
    rd_chk(`RIR_STAT_BASE + 2, 8'h80);
    ready_state_i <= 1'b1;
    cycles(3);
    rd_chk(`RIR_STAT_BASE + 1, 8'h00);
    osc_settled_i <= 1'b1;
    cycles(3);
    rd_chk(`RIR_STAT_BASE + 1, 8'h01);
    // Input functions on pin 2.
    drv_en <= 4'h4;
    for (int c = 0; c < 6; c++) begin
      reg_wr(`RIR_CONF_BASE + 1, 8'(c << 3) | 8'h01);
      cycles(6);
      drv_val <= 4'h4;
      acc = 5'h00;
      cnt = 0;
      repeat (12) begin
        @(posedge mclk_i);
        #1 acc = acc | pin_in_o;
        cnt += (pin_in_o != 5'h00);
      end
      check_eq(acc, (c < 5) ? (5'h10 >> c) : 5'h00);
      if (c < 2) check_eq(cnt, 1);
      @(posedge mclk_i);
      drv_val <= 4'h0;
      cycles(6);
    end
    check_eq(pin_oe_n_o, 4'h4);
    // Output selection codes 1 to 31 on pin 1.
    for (int c = 1; c < 32; c++) begin
      reg_wr(`RIR_CONF_BASE + 2, 8'(c << 3) | 8'h03);
      dev_sig_i <= rir_out_src_t'(31'h1 << (c - 1));
      cycles(3);
      check_eq(pin_o[1], 1'b1);
      dev_sig_i <= ~rir_out_src_t'(31'h1 << (c - 1));
      cycles(3);
      check_eq(pin_o[1], 1'b0);
    end
    finish_test();
  end
endmodule
